// ---- hdl/fdac_ctrl.sv ----
// Frequency tuning converter controller with double-buffered event values
// Behaviour
// - Four indexed update events per frame
// - Frame strobe copies write buffers to active; a same-cycle bus write to active wins
// - Timed event loads matching active buffer
// - Forced mode: powered always; timed mode: powered for period
// - Immediate mode applies written value at once
// - After immediate exit, powered for period; events extend
// - Bit 3 selects active buffer for reads
// - Bit 1 steers writes into active buffers
// - Bit 2 forces power; control resets zero
// - Immediate mode drives write buffer zero only
// - Converter code zero until first update
// - Period register 13 bits, resets to 255
// - Period ignored while immediate or forced
// - Otherwise power enable high for period
// - Converter code is 13 bits
`timescale 1ns/100ps
module fdac_ctrl (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // Peripheral bus
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [fdac_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [fdac_pkg::DATA_W-1:0]   pwdata,
  output logic      [fdac_pkg::DATA_W-1:0]   prdata,
  // Frame timer
  input  wire logic                          frame_valid_strobe,
  input  wire logic                          update_event_pulse,
  input  wire logic [fdac_pkg::EVT_W-1:0]    update_event_index,
  input  wire logic                          qbit_tick,
  // Converter
  output logic      [fdac_pkg::CODE_W-1:0]   converter_code,
  output logic                               converter_power_enable
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [fdac_pkg::CFG_W-1:0]    config_ff;
  logic [fdac_pkg::PERIOD_W-1:0] period_ff;
  logic [fdac_pkg::CODE_W-1:0]   code_ff;
  logic [fdac_pkg::CODE_W-1:0]   nxt_code;
  logic                          power_ff;
  logic                          nxt_power;
  logic [fdac_pkg::DATA_W-1:0]   rdata_ff;
  logic [fdac_pkg::DATA_W-1:0]   nxt_rdata;
  logic                          immediate_prev_ff;

  logic [fdac_pkg::CODE_W-1:0]   wbuf [fdac_pkg::NUM_EVT];
  logic [fdac_pkg::CODE_W-1:0]   abuf [fdac_pkg::NUM_EVT];

  logic                          wr_access;
  logic                          rd_setup;
  logic                          hit_config;
  logic                          hit_period;
  logic [fdac_pkg::NUM_EVT-1:0]  hit_value;

  logic                          immediate_mode;
  logic                          write_active_select;
  logic                          force_power;
  logic                          read_active_select;
  fdac_pkg::fdac_mode_t          mode;

  logic                          timed_event;
  logic                          immediate_exit;
  logic                          timer_restart;
  logic                          timer_busy;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Writes take effect in the access phase
  assign wr_access = psel && penable && pwrite;
  // Read data is registered in the setup phase, valid in the access phase
  assign rd_setup  = psel && !penable && !pwrite;

  assign hit_config = (paddr == fdac_pkg::OFS_CONFIG);
  assign hit_period = (paddr == fdac_pkg::OFS_PERIOD);
  assign hit_value  = {(paddr == fdac_pkg::OFS_VALUE3),
                       (paddr == fdac_pkg::OFS_VALUE2),
                       (paddr == fdac_pkg::OFS_VALUE1),
                       (paddr == fdac_pkg::OFS_VALUE0)};

  // ****************************************************************
  // Control register
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_ff <= fdac_pkg::RST_CONFIG;
    end else if (wr_access && hit_config) begin
      config_ff <= pwdata[fdac_pkg::CFG_W-1:0];
    end
  end

  assign immediate_mode      = config_ff[fdac_pkg::BIT_IMMEDIATE];
  assign write_active_select = config_ff[fdac_pkg::BIT_WR_ACTIVE];
  assign force_power         = config_ff[fdac_pkg::BIT_FORCE_PWR];
  assign read_active_select  = config_ff[fdac_pkg::BIT_RD_ACTIVE];

  // ****************************************************************
  // Power-up period register
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_ff <= fdac_pkg::RST_PERIOD;
    end else if (wr_access && hit_period) begin
      period_ff <= pwdata[fdac_pkg::PERIOD_W-1:0];
    end
  end

  // ****************************************************************
  // Event value buffers
  // ****************************************************************
  // No reset on the value buffers; software loads them first
  genvar gi;
  generate
    for (gi = 0; gi < fdac_pkg::NUM_EVT; gi++) begin : g_entry
      // Write buffer: bus writes when the active path is not selected
      always_ff @(posedge sys_clk) begin
        if (wr_access && hit_value[gi] && !write_active_select) begin
          wbuf[gi] <= pwdata[fdac_pkg::CODE_W-1:0];
        end
      end

      // Active buffer: direct bus write wins over the frame copy
      always_ff @(posedge sys_clk) begin
        if (wr_access && hit_value[gi] && write_active_select) begin
          abuf[gi] <= pwdata[fdac_pkg::CODE_W-1:0];
        end else if (frame_valid_strobe) begin
          abuf[gi] <= wbuf[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Operating mode
  // ****************************************************************
  always_comb begin
    if (immediate_mode) begin
      mode = fdac_pkg::MODE_IMMEDIATE;
    end else if (force_power) begin
      mode = fdac_pkg::MODE_FORCED;
    end else begin
      mode = fdac_pkg::MODE_TIMED;
    end
  end

  // Events count only outside immediate mode
  assign timed_event = update_event_pulse && !immediate_mode;

  // ****************************************************************
  // Converter output register
  // ****************************************************************
  always_comb begin
    nxt_code = code_ff;
    case (mode)
      fdac_pkg::MODE_IMMEDIATE: begin
        nxt_code = wbuf[0];
      end
      fdac_pkg::MODE_FORCED,
      fdac_pkg::MODE_TIMED: begin
        if (update_event_pulse) begin
          nxt_code = abuf[update_event_index];
        end
      end
      default: begin
        nxt_code = code_ff;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_ff <= fdac_pkg::RST_CODE;
    end else begin
      code_ff <= nxt_code;
    end
  end

  assign converter_code = code_ff;

  // ****************************************************************
  // Power control
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      immediate_prev_ff <= 1'b0;
    end else begin
      immediate_prev_ff <= immediate_mode;
    end
  end

  // Leaving immediate mode starts a fresh powered period
  assign immediate_exit = immediate_prev_ff && !immediate_mode;
  // Each timed event restarts the period so it is extended
  assign timer_restart  = immediate_exit || timed_event;

  fdac_power_timer u_power_timer (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .qbit_tick (qbit_tick),
    .restart   (timer_restart),
    .period    (period_ff),
    .busy      (timer_busy)
  );

  always_comb begin
    nxt_power = 1'b0;
    case (mode)
      fdac_pkg::MODE_IMMEDIATE,
      fdac_pkg::MODE_FORCED: begin
        nxt_power = 1'b1;
      end
      fdac_pkg::MODE_TIMED: begin
        nxt_power = timer_busy || timer_restart;
      end
      default: begin
        nxt_power = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_ff <= 1'b0;
    end else begin
      power_ff <= nxt_power;
    end
  end

  assign converter_power_enable = power_ff;

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    nxt_rdata = fdac_pkg::RD_ZERO;
    if (hit_config) begin
      nxt_rdata[fdac_pkg::CFG_W-1:0] = config_ff;
    end else if (hit_period) begin
      nxt_rdata[fdac_pkg::PERIOD_W-1:0] = period_ff;
    end else begin
      for (int i = 0; i < fdac_pkg::NUM_EVT; i++) begin
        if (hit_value[i]) begin
          if (read_active_select) begin
            nxt_rdata[fdac_pkg::CODE_W-1:0] = abuf[i];
          end else begin
            nxt_rdata[fdac_pkg::CODE_W-1:0] = wbuf[i];
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= fdac_pkg::RD_ZERO;
    end else if (rd_setup) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign prdata = rdata_ff;

endmodule

// ---- hdl/fdac_pkg.sv ----
// Shared constants and types of the frequency converter controller
package fdac_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 16;
  localparam int CODE_W   = 13;
  localparam int PERIOD_W = 13;
  localparam int NUM_EVT  = 4;
  localparam int EVT_W    = 2;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_VALUE0 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_VALUE1 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_VALUE2 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_VALUE3 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h14;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CFG_W          = 4;
  localparam int BIT_IMMEDIATE  = 0;
  localparam int BIT_WR_ACTIVE  = 1;
  localparam int BIT_FORCE_PWR  = 2;
  localparam int BIT_RD_ACTIVE  = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [CFG_W-1:0]    RST_CONFIG = 4'h0;
  localparam logic [PERIOD_W-1:0] RST_PERIOD = 13'h00FF;
  localparam logic [CODE_W-1:0]   RST_CODE   = 13'h0000;
  localparam logic [DATA_W-1:0]   RD_ZERO    = 16'h0000;

  // ****************************************************************
  // Modes
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_TIMED,
    MODE_FORCED,
    MODE_IMMEDIATE
  } fdac_mode_t;

endpackage

// ---- hdl/fdac_power_timer.sv ----
// Quarter-bit power-up period counter of the converter
`timescale 1ns/100ps
module fdac_power_timer (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // Control
  input  wire logic                          qbit_tick,
  input  wire logic                          restart,
  input  wire logic [fdac_pkg::PERIOD_W-1:0] period,
  // Status
  output logic                               busy
);

  // ****************************************************************
  // Down counter
  // ****************************************************************
  localparam logic [fdac_pkg::PERIOD_W-1:0] CNT_ZERO = 13'h0000;
  localparam logic [fdac_pkg::PERIOD_W-1:0] CNT_ONE  = 13'h0001;

  logic [fdac_pkg::PERIOD_W-1:0] count_ff;
  logic [fdac_pkg::PERIOD_W-1:0] nxt_count;

  always_comb begin
    nxt_count = count_ff;
    if (restart) begin
      nxt_count = period;
    end else if (qbit_tick && (count_ff != CNT_ZERO)) begin
      nxt_count = count_ff - CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= CNT_ZERO;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Powered for exactly the loaded number of ticks
  assign busy = (count_ff != CNT_ZERO);

endmodule

// ---- tb/fdac_ctrl_asserts.sv ----
// Port-level checker of the converter controller
`timescale 1ns/100ps
module fdac_ctrl_chk (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [15:0] pwdata,
  input wire logic [15:0] prdata,
  // Timer
  input wire logic        frame_valid_strobe,
  input wire logic        update_event_pulse,
  input wire logic [1:0]  update_event_index,
  input wire logic        qbit_tick,
  // Converter
  input wire logic [12:0] converter_code,
  input wire logic        converter_power_enable
);
  // ****
  // Shadow of control and period
  // ****
  logic [3:0]  cfg_ff;
  logic [12:0] per_ff;
  logic        wr_acc;
  logic        rd_set;
  assign wr_acc = psel && penable && pwrite;
  assign rd_set = psel && !penable && !pwrite;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= 4'h0;
    end else if (wr_acc && paddr == 8'h00) begin
      cfg_ff <= pwdata[3:0];
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_ff <= 13'h00FF;
    end else if (wr_acc && paddr == 8'h14) begin
      per_ff <= pwdata[12:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_code_hold;
    !update_event_pulse && !cfg_ff[0] && !$past(cfg_ff[0]) |=> $stable(converter_code);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("code moved");
  property p_evt_pwr;
    update_event_pulse && !cfg_ff[0] |=> converter_power_enable;
  endproperty
  a_evt_pwr: assert property (p_evt_pwr) else $error("no power on event");
  property p_force;
    cfg_ff[2] |=> converter_power_enable;
  endproperty
  a_force: assert property (p_force) else $error("no power when forced");
  property p_imm_pwr;
    cfg_ff[0] |=> converter_power_enable;
  endproperty
  a_imm_pwr: assert property (p_imm_pwr) else $error("no power in immediate");
  property p_imm_code;
    wr_acc && paddr == 8'h04 && cfg_ff[0] && !cfg_ff[1]
      |=> ##1 converter_code == $past(pwdata[12:0], 2);
  endproperty
  a_imm_code: assert property (p_imm_code) else $error("immediate code");
  property p_rd_high;
    rd_set && paddr inside {8'h04, 8'h08, 8'h0C, 8'h10, 8'h14} |=> prdata[15:13] == 3'h0;
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("upper bits set");
  property p_rd_cfg;
    rd_set && paddr == 8'h00 |=> prdata == {12'h000, $past(cfg_ff)};
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("control read");
  property p_rd_per;
    rd_set && paddr == 8'h14 |=> prdata == {3'h0, $past(per_ff)};
  endproperty
  a_rd_per: assert property (p_rd_per) else $error("period read");
  property p_rd_hold;
    !$past(rd_set) |-> $stable(prdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule
bind fdac_ctrl fdac_ctrl_chk i_chk (
  .sys_clk                (sys_clk),
  .rst_n                  (rst_n),
  .psel                   (psel),
  .penable                (penable),
  .pwrite                 (pwrite),
  .paddr                  (paddr),
  .pwdata                 (pwdata),
  .prdata                 (prdata),
  .frame_valid_strobe     (frame_valid_strobe),
  .update_event_pulse     (update_event_pulse),
  .update_event_index     (update_event_index),
  .qbit_tick              (qbit_tick),
  .converter_code         (converter_code),
  .converter_power_enable (converter_power_enable)
);

// ---- tb/fdac_timer_model.sv ----
// Frame timer model: frame strobe, indexed events, quarter-bit ticks
`timescale 1ns/100ps
module fdac_timer_model #(
  parameter int QDIV = 4
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Timer pulses
  output logic       frame_valid_strobe,
  output logic       update_event_pulse,
  output logic [1:0] update_event_index,
  output logic       qbit_tick
);
  int         qcnt = 0;
  bit         ev_req = 0;
  bit         fr_req = 0;
  logic [1:0] ev_k = 2'h0;
  initial begin
    frame_valid_strobe = 1'b0;
    update_event_pulse = 1'b0;
    update_event_index = 2'h0;
    qbit_tick = 1'b0;
  end
  // ****
  // One-cycle pulses from the falling edge
  // ****
  always @(negedge sys_clk) begin
    qcnt = rst_n ? (qcnt + 1) % QDIV : 0;
    qbit_tick <= rst_n && qcnt == 0;
    update_event_pulse <= ev_req;
    update_event_index <= ev_req ? ev_k : update_event_index + 2'h1;
    frame_valid_strobe <= fr_req;
    ev_req = 0;
    fr_req = 0;
  end
  task automatic fire_event(input logic [1:0] k);
    @(posedge sys_clk);
    ev_k = k;
    ev_req = 1;
    @(negedge sys_clk);
  endtask
  task automatic fire_frame;
    @(posedge sys_clk);
    fr_req = 1;
    @(negedge sys_clk);
  endtask
endmodule

// ---- tb/fdac_ctrl_test.sv ----
// Self-checking bench of the converter controller
`timescale 1ns/100ps
module fdac_ctrl_test;
  localparam logic [15:0] PER = 16'h0005;
  logic        sys_clk, rst_n, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [15:0] pwdata, prdata, rd;
  logic        frame_valid_strobe, update_event_pulse, qbit_tick;
  logic [1:0]  update_event_index;
  logic [12:0] converter_code;
  logic        converter_power_enable;
  int          err_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          n;
  fdac_ctrl i_dut (
    .sys_clk                (sys_clk),
    .rst_n                  (rst_n),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .frame_valid_strobe     (frame_valid_strobe),
    .update_event_pulse     (update_event_pulse),
    .update_event_index     (update_event_index),
    .qbit_tick              (qbit_tick),
    .converter_code         (converter_code),
    .converter_power_enable (converter_power_enable)
  );
  fdac_timer_model #(.QDIV(4)) i_tmr (
    .sys_clk                (sys_clk),
    .rst_n                  (rst_n),
    .frame_valid_strobe     (frame_valid_strobe),
    .update_event_pulse     (update_event_pulse),
    .update_event_index     (update_event_index),
    .qbit_tick              (qbit_tick)
  );
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ****
  // Tasks
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(negedge sys_clk);
    penable = 1'b1;
    @(negedge sys_clk);
    rd = prdata;
    psel = 1'b0;
    penable = 1'b0;
    paddr = ~a;
    pwdata = ~d;
  endtask
  task automatic pwr_count;
    n = 0;
    @(negedge sys_clk);
    repeat (200) begin
      @(negedge sys_clk);
      if (converter_power_enable !== 1'b1) break;
      if (qbit_tick) n++;
    end
  endtask
  task automatic wrap_up;
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      wrap_up();
    end
  end
  // ****
  // Sequence
  // ****
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 16'h0000;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    check({3'h0, converter_code}, 16'h0000);
    bus(0, 8'h00, 16'h0000);
    check(rd, 16'h0000);
    bus(0, 8'h14, 16'h0000);
    check(rd, 16'h00FF);
    bus(1, 8'h14, 16'hFFFF);
    bus(0, 8'h14, 16'h0000);
    check(rd, 16'h1FFF);
    bus(1, 8'h18, 16'hFFFF);
    bus(0, 8'h18, 16'h0000);
    check(rd, 16'h0000);
    bus(1, 8'h14, PER);
    bus(1, 8'h00, 16'h0002);
    for (int k = 0; k < 4; k++) begin
      bus(1, 8'(4 * k + 4), 16'hE000 | (16'h0A00 + 16'(k)));
    end
    bus(1, 8'h00, 16'h0000);
    for (int k = 0; k < 4; k++) bus(1, 8'(4 * k + 4), 16'hE000 | (16'h1500 + 16'(k)));
    for (int k = 0; k < 4; k++) begin
      bus(0, 8'(4 * k + 4), 16'h0000);
      check(rd, 16'h1500 + 16'(k));
    end
    bus(1, 8'h00, 16'h0008);
    for (int k = 0; k < 4; k++) begin
      bus(0, 8'(4 * k + 4), 16'h0000);
      check(rd, 16'h0A00 + 16'(k));
    end
    for (int k = 3; k >= 0; k--) begin
      i_tmr.fire_event(2'(k));
      repeat (2) @(negedge sys_clk);
      check({3'h0, converter_code}, 16'h0A00 + 16'(k));
    end
    i_tmr.fire_frame();
    repeat (2) @(negedge sys_clk);
    for (int k = 0; k < 4; k++) begin
      bus(0, 8'(4 * k + 4), 16'h0000);
      check(rd, 16'h1500 + 16'(k));
    end
    i_tmr.fire_event(2'd1);
    i_tmr.fire_event(2'd2);
    repeat (2) @(negedge sys_clk);
    check({3'h0, converter_code}, 16'h1502);
    i_tmr.fire_event(2'd0);
    pwr_count();
    check(16'(n), PER);
    check({15'h0, converter_power_enable}, 16'h0000);
    i_tmr.fire_event(2'd1);
    repeat (10) @(negedge sys_clk);
    i_tmr.fire_event(2'd3);
    pwr_count();
    check(16'(n), PER);
    bus(1, 8'h00, 16'h0004);
    repeat (100) @(negedge sys_clk);
    check({15'h0, converter_power_enable}, 16'h0001);
    bus(1, 8'h04, 16'h0123);
    bus(1, 8'h00, 16'h0005);
    repeat (2) @(negedge sys_clk);
    check({3'h0, converter_code}, 16'h0123);
    bus(1, 8'h04, 16'h0456);
    @(negedge sys_clk);
    check({3'h0, converter_code}, 16'h0456);
    i_tmr.fire_event(2'd3);
    repeat (2) @(negedge sys_clk);
    check({3'h0, converter_code}, 16'h0456);
    bus(1, 8'h00, 16'h0000);
    pwr_count();
    check(16'(n), PER);
    wrap_up();
  end
endmodule
